// *** design/pdaf_top.sv ***
// pdaf_top: port-d alternate function override with the mcu control register over apb
// assumes: port data/direction registers live elsewhere and arrive as plain inputs;
// peripherals supply enables and waveforms synchronous to clk
//
// Register access over APB was left to the implementer.
module pdaf_top
    import pdaf_pkg::*;
(
    input wire logic clk,                 // 50 MHz system clock
    input wire logic rst_b,               // synchronous reset, active low
    input wire logic psel,                // apb select
    input wire logic penable,             // apb enable
    input wire logic pwrite,              // apb write
    input wire logic [31:0] paddr,        // apb byte address
    input wire logic [31:0] pwdata,       // apb write data
    input wire logic [3:0] pstrb,         // apb byte strobes
    output logic [31:0] prdata,           // apb read data
    output logic pready,                  // apb ready
    output logic pslverr,                 // apb error, unmapped address
    input wire logic [7:0] port_data,     // port data register bits
    input wire logic [7:0] dir_bits,      // port direction register bits
    input wire logic [7:0] pin_in,        // pin levels
    input wire logic brownout_sleep,      // read-only status bit from power logic
    input wire logic brownout_sleep_enable, // read-only status bit from power logic
    input wire pdaf_pkg::pdaf_periph_s periph, // peripheral controls and waveforms
    output logic [7:0] pin_out,           // pin output values
    output logic [7:0] pin_oe,            // pin output enables, high = driving
    output logic [7:0] pin_pullup,        // pull-up enables
    output logic [7:0] pin_din_en,        // digital input enables
    output pdaf_pkg::pdaf_inputs_s alt_in, // alternate-function inputs
    output logic pullup_disable,          // global pull-up disable
    output logic vector_select,           // vector select bit
    output logic vector_change_enable     // vector change enable bit
);
    import pdaf_pkg::*;

    // -----------------------------------------------------------------
    // register bus
    // -----------------------------------------------------------------
    logic [7:0] mcu_control_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic access;
    logic hit;
    logic [7:0] status_byte;

    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = (a[31:10] == 22'h0) && (a[9:0] == PDAF_MCU_CONTROL_ADDR);
    endfunction

    assign access = psel & penable & ~pready_q;
    assign hit = addr_hit(paddr);

    // live status bits merged at read time; unused bits read zero
    always_comb begin
        status_byte = mcu_control_q & PDAF_MCU_CONTROL_WMASK;
        status_byte[PDAF_BROWNOUT_SLEEP_BIT] = brownout_sleep;
        status_byte[PDAF_BROWNOUT_SLEEP_EN_BIT] = brownout_sleep_enable;
    end

    // one wait state: ready rises in the second access cycle, then drops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access & ~hit;
            if (access && !pwrite) begin
                if (hit) begin
                    prdata_q <= {24'h0, status_byte};
                end else begin
                    prdata_q <= PDAF_UNMAPPED_RDATA;
                end
            end
        end
    end

    // writes land on the edge at which ready is sampled high
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mcu_control_q <= PDAF_MCU_CONTROL_RST;
        end else if (psel && penable && pready_q && pwrite && hit && pstrb[0]) begin
            // only pull-up disable and vector bits are writable
            mcu_control_q <= (pwdata[7:0] & PDAF_MCU_CONTROL_WMASK) |
                             (mcu_control_q & ~PDAF_MCU_CONTROL_WMASK);
        end
    end

    // -----------------------------------------------------------------
    // override generation
    // -----------------------------------------------------------------
    pdaf_ovr_s ovr [8];
    logic [7:0] pc_cond;
    logic pu_off;

    assign pu_off = mcu_control_q[PDAF_PULLUP_DISABLE_BIT];
    assign pc_cond = periph.pin_change_mask & {8{periph.pin_change_bank2_en}};

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // default: only the pin-change input override
            ovr[i] = '0;
            ovr[i].din_en_ovr_en = pc_cond[i];
            ovr[i].din_en_ovr_val = 1'b1;
        end
        // compare outputs replace the value only; direction stays with software
        ovr[6].outval_ovr_en = periph.timer0_cmp_a_en;
        ovr[6].outval_ovr_val = periph.timer0_cmp_a_out;
        ovr[5].outval_ovr_en = periph.timer0_cmp_b_en;
        ovr[5].outval_ovr_val = periph.timer0_cmp_b_out;
        ovr[4].outval_ovr_en = periph.serial_mode_select;
        ovr[4].outval_ovr_val = periph.serial_ext_clock;
        ovr[3].outval_ovr_en = periph.timer2_cmp_b_en;
        ovr[3].outval_ovr_val = periph.timer2_cmp_b_out;
        ovr[3].din_en_ovr_en = periph.ext_irq_1_en | pc_cond[3];
        ovr[2].din_en_ovr_en = periph.ext_irq_0_en | pc_cond[2];
        // transmitter owns pull-up, direction and value of pin 1
        ovr[1].pullup_ovr_en = periph.serial_tx_enable;
        ovr[1].pullup_ovr_val = 1'b0;
        ovr[1].dir_ovr_en = periph.serial_tx_enable;
        ovr[1].dir_ovr_val = 1'b1;
        ovr[1].outval_ovr_en = periph.serial_tx_enable;
        ovr[1].outval_ovr_val = periph.serial_tx_data;
        // receiver forces input; pull-up still follows data bit unless globally off
        ovr[0].pullup_ovr_en = periph.serial_rx_enable;
        ovr[0].pullup_ovr_val = port_data[0] & ~pu_off;
        ovr[0].dir_ovr_en = periph.serial_rx_enable;
        ovr[0].dir_ovr_val = 1'b0;
    end

    // -----------------------------------------------------------------
    // per-pin merge
    // -----------------------------------------------------------------
    logic [7:0] pu_d;
    logic [7:0] oe_d;
    logic [7:0] out_d;
    logic [7:0] die_d;

    generate
        for (genvar g = 0; g < 8; g++) begin : g_pin
            pdaf_pin u_pin (
                .port_data(port_data[g]),
                .dir_bit(dir_bits[g]),
                .pullup_disable(pu_off),
                .ovr(ovr[g]),
                .pullup_on(pu_d[g]),
                .drive_en(oe_d[g]),
                .drive_val(out_d[g]),
                .din_en(die_d[g])
            );
        end
    endgenerate

    // -----------------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------------
    logic [7:0] pin_out_q;
    logic [7:0] pin_oe_q;
    logic [7:0] pin_pullup_q;
    logic [7:0] pin_din_en_q;
    pdaf_inputs_s alt_in_q;
    logic [7:0] din;

    // a disabled digital input reads low so floating analog pins do not toggle logic
    assign din = pin_in & die_d;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_out_q <= 8'h00;
            pin_oe_q <= 8'h00;
            pin_pullup_q <= 8'h00;
            pin_din_en_q <= 8'h00;
        end else begin
            pin_out_q <= out_d;
            pin_oe_q <= oe_d;
            pin_pullup_q <= pu_d;
            pin_din_en_q <= die_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alt_in_q <= '0;
        end else begin
            alt_in_q.serial_rx_data <= din[0];
            alt_in_q.serial_clock_in <= din[4];
            alt_in_q.timer0_count_in <= din[4];
            alt_in_q.timer1_count_in <= din[5];
            alt_in_q.ext_irq_0 <= din[2];
            alt_in_q.ext_irq_1 <= din[3];
            alt_in_q.pin_change_src <= din;
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign pin_pullup = pin_pullup_q;
    assign pin_din_en = pin_din_en_q;
    assign alt_in = alt_in_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pullup_disable = mcu_control_q[PDAF_PULLUP_DISABLE_BIT];
    assign vector_select = mcu_control_q[PDAF_VECTOR_SELECT_BIT];
    assign vector_change_enable = mcu_control_q[PDAF_VECTOR_CHANGE_EN_BIT];
endmodule

// *** design/pdaf_pkg.sv ***
// pdaf_pkg: constants and carrier types for the port-d alternate function override block
// assumes: single 50 MHz clock, synchronous active-low reset, apb register access
//
// Functional notes
// - pin 6 carries the timer-0 compare-a waveform when its output is enabled.
// - pin 5 carries the timer-0 compare-b waveform when its output is enabled.
// - pin 3 carries the timer-2 compare-b waveform when its output is enabled.
// - with the transmitter on, pin 1 is forced to output, pull-up off, value from tx data.
// - with the receiver on, pin 0 is forced to input and feeds the receive path.
// - with the receiver forcing pin 0, its pull-up follows its data bit gated by disable.
// - pin 4 takes its value from the serial clock when the mode select enables it and feeds clock input.
// - pin 4 feeds timer-0 count input and pin 5 feeds timer-1 count input.
// - each pin is pin-change source 16..23; input forced on by mask bit and bank-2 enable.
// - pin 3 is external irq 1; input forced on by its enable or source 19 condition.
// - pin 2 is external irq 0; input forced on by its enable or source 18 condition.
// - pins 7..4 have no pull-up or direction override; pins 3, 2 likewise, pin 2 no value.
// - mcu control register at offset 0x35 holds the read/write pull-up disable at bit 4.
// - bits 1, 0 read/write; bits 6, 5 read only; bits 7, 3, 2 read zero.
// - the pull-up disable bit turns off every port pull-up.
package pdaf_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0] PDAF_MCU_CONTROL_IDX = 8'h35;
    localparam logic [9:0] PDAF_MCU_CONTROL_ADDR = {PDAF_MCU_CONTROL_IDX, 2'b00};
    localparam logic [7:0] PDAF_MCU_CONTROL_RST = 8'h00;
    localparam logic [7:0] PDAF_MCU_CONTROL_WMASK = 8'h13;
    localparam int PDAF_PULLUP_DISABLE_BIT = 4;
    localparam int PDAF_BROWNOUT_SLEEP_BIT = 6;
    localparam int PDAF_BROWNOUT_SLEEP_EN_BIT = 5;
    localparam int PDAF_VECTOR_SELECT_BIT = 1;
    localparam int PDAF_VECTOR_CHANGE_EN_BIT = 0;
    localparam logic [31:0] PDAF_UNMAPPED_RDATA = 32'h0000_0000;

    // -----------------------------------------------------------------
    // carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic pullup_ovr_en;
        logic pullup_ovr_val;
        logic dir_ovr_en;
        logic dir_ovr_val;
        logic outval_ovr_en;
        logic outval_ovr_val;
        logic din_en_ovr_en;
        logic din_en_ovr_val;
    } pdaf_ovr_s;

    typedef struct packed {
        logic serial_tx_enable;
        logic serial_tx_data;
        logic serial_rx_enable;
        logic serial_mode_select;
        logic serial_ext_clock;
        logic timer0_cmp_a_en;
        logic timer0_cmp_a_out;
        logic timer0_cmp_b_en;
        logic timer0_cmp_b_out;
        logic timer2_cmp_b_en;
        logic timer2_cmp_b_out;
        logic ext_irq_0_en;
        logic ext_irq_1_en;
        logic pin_change_bank2_en;
        logic [7:0] pin_change_mask;
    } pdaf_periph_s;

    typedef struct packed {
        logic serial_rx_data;
        logic serial_clock_in;
        logic timer0_count_in;
        logic timer1_count_in;
        logic ext_irq_0;
        logic ext_irq_1;
        logic [7:0] pin_change_src;
    } pdaf_inputs_s;

endpackage

// *** design/pdaf_pin.sv ***
// pdaf_pin: one port pin, register values merged with alternate-function overrides
// assumes: override bundle comes from the owning block; pin sampled synchronously
module pdaf_pin
    import pdaf_pkg::*;
(
    input wire logic port_data,      // port data bit
    input wire logic dir_bit,        // direction bit, 1 = output
    input wire logic pullup_disable, // global pull-up disable
    input wire pdaf_pkg::pdaf_ovr_s ovr, // override bundle
    output logic pullup_on,          // pull-up active
    output logic drive_en,           // output driver enabled
    output logic drive_val,          // output value
    output logic din_en              // digital input enabled
);
    logic pu_reg;

    // pull-up only for input with data bit set, never under the global disable
    assign pu_reg = port_data & ~dir_bit & ~pullup_disable;
    assign pullup_on = ovr.pullup_ovr_en ? ovr.pullup_ovr_val : pu_reg;
    assign drive_en = ovr.dir_ovr_en ? ovr.dir_ovr_val : dir_bit;
    assign drive_val = ovr.outval_ovr_en ? ovr.outval_ovr_val : port_data;
    // digital input is on unless something turns it off; sleep gating is outside this block
    assign din_en = ovr.din_en_ovr_en ? ovr.din_en_ovr_val : 1'b1;
endmodule

// *** bench/pdaf_properties.sv ***
// pdaf_properties: concurrent checks on the outputs of pdaf_top
// assumes: bound to pdaf_top; pin outputs lag their inputs by one clock
module pdaf_properties
    import pdaf_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pready, // apb ready
    input wire logic [7:0] port_data, // port data bits
    input wire logic [7:0] dir_bits, // direction bits
    input wire logic [7:0] pin_in, // pin levels
    input wire pdaf_pkg::pdaf_periph_s periph, // peripheral controls
    input wire logic [7:0] pin_out, // pin values
    input wire logic [7:0] pin_oe, // pin output enables
    input wire logic [7:0] pin_pullup, // pull-ups
    input wire logic [7:0] pin_din_en, // input enables
    input wire pdaf_pkg::pdaf_inputs_s alt_in, // alternate inputs
    input wire logic pullup_disable // global pull-up disable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_tx_takes_pin: assert property (
        periph.serial_tx_enable |=> pin_oe[1] && !pin_pullup[1]
        && pin_out[1] == $past(periph.serial_tx_data)) else $error("tx pin override wrong");
    chk_rx_takes_pin: assert property (
        periph.serial_rx_enable |=> !pin_oe[0]
        && pin_pullup[0] == $past(port_data[0] & ~pullup_disable)) else $error("rx pin wrong");
    chk_cmp_a_out: assert property (
        periph.timer0_cmp_a_en |=> pin_out[6] == $past(periph.timer0_cmp_a_out)
        && pin_oe[6] == $past(dir_bits[6])) else $error("compare a pin wrong");
    chk_cmp_b_out: assert property (
        periph.timer0_cmp_b_en |=> pin_out[5] == $past(periph.timer0_cmp_b_out)
        && pin_oe[5] == $past(dir_bits[5])) else $error("compare b pin wrong");
    chk_t2_cmp_out: assert property (
        periph.timer2_cmp_b_en |=> pin_out[3] == $past(periph.timer2_cmp_b_out)
        && pin_oe[3] == $past(dir_bits[3])) else $error("timer2 compare pin wrong");
    chk_clock_out: assert property (
        periph.serial_mode_select |=> pin_out[4] == $past(periph.serial_ext_clock))
        else $error("serial clock pin wrong");
    chk_pullups_off: assert property (
        pullup_disable |=> pin_pullup == 8'h00) else $error("pull-up while disabled");
    chk_plain_pins: assert property (
        rst_b |=> pin_oe[7] == $past(dir_bits[7]) && pin_out[7] == $past(port_data[7])
        && pin_oe[2] == $past(dir_bits[2]) && pin_out[2] == $past(port_data[2])
        && pin_pullup[7] == $past(port_data[7] & ~dir_bits[7] & ~pullup_disable))
        else $error("plain pin override seen");
    chk_din_paths: assert property (
        rst_b |=> pin_din_en == 8'hff && alt_in.pin_change_src == $past(pin_in)
        && alt_in.timer1_count_in == $past(pin_in[5])) else $error("input path wrong");
    chk_apb_wait: assert property (
        psel && penable && !pready |=> pready ##1 !pready) else $error("apb answer late");
endmodule

// *** bench/pdaf_periph_model.sv ***
// pdaf_periph_model: timers and serial port seen from the pins
// assumes: bench supplies enables; waveforms here toggle every 1, 2, 4 or 8 clocks
module pdaf_periph_model
    import pdaf_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire pdaf_pkg::pdaf_periph_s ctl, // enables from the bench
    output pdaf_pkg::pdaf_periph_s periph // controls and waveforms
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase_q;
    always_ff @(posedge clk) begin
        phase_q <= rst_b ? phase_q + 4'h1 : 4'h0;
    end
    // serial clock stands still unless the clock output is selected
    always_comb begin
        periph = ctl;
        periph.timer0_cmp_a_out = phase_q[0];
        periph.timer0_cmp_b_out = phase_q[1];
        periph.timer2_cmp_b_out = phase_q[2];
        periph.serial_tx_data = phase_q[3];
        periph.serial_ext_clock = ctl.serial_mode_select & phase_q[0];
    end
endmodule

// *** bench/test_pdaf_top.sv ***
// test_pdaf_top: self-checking bench for the port-d override block
// assumes: pdaf_periph_model stands in for timers and serial port
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module test_pdaf_top import pdaf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, bo, boe, pu_off, vsel, vce, er;
    logic [3:0] strb;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0] port_data, dir_bits, pin_in, pin_out, pin_oe, pin_pullup, pin_din_en;
    pdaf_periph_s ctl, periph, c;
    pdaf_inputs_s alt_in;
    int n_mismatch = 0, samples_checked = 0;
    localparam logic [31:0] ADDR = 32'(PDAF_MCU_CONTROL_ADDR);
    pdaf_periph_model i_model (.clk(clk), .rst_b(rst_b), .ctl(ctl), .periph(periph));
    pdaf_top i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_data(port_data), .dir_bits(dir_bits), .pin_in(pin_in),
        .brownout_sleep(bo), .brownout_sleep_enable(boe), .periph(periph), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_din_en(pin_din_en), .alt_in(alt_in),
        .pullup_disable(pu_off), .vector_select(vsel), .vector_change_enable(vce));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic apb(input logic w, input logic [31:0] a, wd);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: a missing answer is left to the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_pins(input pdaf_periph_s s, input logic [7:0] pd, dr, pi, input logic u);
        logic [7:0] oe, o, pu;
        oe = dr; o = pd; pu = pd & ~dr & ~{8{u}};
        if (s.timer0_cmp_a_en) o[6] = s.timer0_cmp_a_out;
        if (s.timer0_cmp_b_en) o[5] = s.timer0_cmp_b_out;
        if (s.timer2_cmp_b_en) o[3] = s.timer2_cmp_b_out;
        if (s.serial_mode_select) o[4] = s.serial_ext_clock;
        if (s.serial_tx_enable) begin oe[1] = 1'b1; o[1] = s.serial_tx_data; pu[1] = 1'b0; end
        if (s.serial_rx_enable) begin oe[0] = 1'b0; pu[0] = pd[0] & ~u; end
        #1;
        `CHK("pin_out", o, pin_out)
        `CHK("pin_oe", oe, pin_oe)
        `CHK("pin_pullup", pu, pin_pullup)
        `CHK("din_en", 8'hff, pin_din_en)
        `CHK("change src", pi, alt_in.pin_change_src)
        `CHK("rx data", pi[0], alt_in.serial_rx_data)
        `CHK("t1 count", pi[5], alt_in.timer1_count_in)
        `CHK("t0 count", pi[4], alt_in.timer0_count_in)
        `CHK("clock in", pi[4], alt_in.serial_clock_in)
        `CHK("irq in", pi[3:2], {alt_in.ext_irq_1, alt_in.ext_irq_0})
    endtask
    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        // comparator pins idle as inputs without pull-up
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        port_data = '0; dir_bits = '0; pin_in = '0; bo = 1'b0; boe = 1'b0; ctl = '0;
        strb = 4'hf;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        `CHK("oe in reset", 8'h00, pin_oe)
        apb(1'b0, ADDR, 0); `CHK("mcu reset", 32'h0, rd)
        apb(1'b1, ADDR, 32'hff); apb(1'b0, ADDR, 0); `CHK("mcu rw", 32'h13, rd)
        `CHK("bits out", 3'b111, {pu_off, vsel, vce})
        bo <= 1'b1; boe <= 1'b1;
        apb(1'b1, ADDR, 32'h0); apb(1'b0, ADDR, 0); `CHK("mcu ro", 32'h60, rd)
        apb(1'b0, ADDR + 4, 0); `CHK("unmapped", 33'h1_0000_0000, {er, rd})
        apb(1'b1, 32'h0, 32'hff); apb(1'b0, ADDR, 0); `CHK("stray write", 32'h60, rd)
        // a write without its low byte strobe must leave the register alone
        strb <= 4'he;
        apb(1'b1, ADDR, 32'hff);
        strb <= 4'hf;
        apb(1'b0, ADDR, 0);
        `CHK("strobe off", 32'h60, rd)
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, ADDR, 32'(p) << 4);
            for (int i = 0; i < 64; i++) begin
                @(posedge clk);
                c = '0;
                {c.timer2_cmp_b_en, c.timer0_cmp_b_en, c.timer0_cmp_a_en} = 3'(i >> 3);
                {c.serial_mode_select, c.serial_rx_enable, c.serial_tx_enable} = 3'(i);
                {c.pin_change_bank2_en, c.ext_irq_1_en, c.ext_irq_0_en} = 3'(i);
                c.pin_change_mask = 8'(i * 3);
                ctl <= c;
                port_data <= 8'(i * 37 + p);
                dir_bits <= 8'(i * 11);
                pin_in <= 8'(i * 5 + p);
                @(posedge clk);
                check_pins(periph, port_data, dir_bits, pin_in, pu_off);
            end
        end
        give_verdict();
    end
endmodule
bind pdaf_top pdaf_properties u_props (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pready(pready), .port_data(port_data), .dir_bits(dir_bits),
    .pin_in(pin_in), .periph(periph), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_din_en(pin_din_en), .alt_in(alt_in),
    .pullup_disable(pullup_disable));
